// *** timer8_pkg.sv ***
// Shared constants and types of the 8-bit timer/counter core
package timer8_pkg;

  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned PRESC_W = 10;
  localparam int unsigned FLAG_W  = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CMP_A  = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_CMP_B  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_FLAG   = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_POWER  = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

  // Field positions
  localparam int unsigned CA_MODE_LSB   = 0;
  localparam int unsigned CA_TOPSEL_BIT = 2;
  localparam int unsigned CA_COMB_LSB   = 4;
  localparam int unsigned CA_COMA_LSB   = 6;
  localparam int unsigned CB_CS_LSB     = 0;
  localparam int unsigned FLG_OVF       = 0;
  localparam int unsigned FLG_CMPA      = 1;
  localparam int unsigned FLG_CMPB      = 2;
  localparam int unsigned PWR_OFF_BIT   = 0;

  // Count values and reset values
  localparam logic [DATA_W-1:0] CNT_BOTTOM  = 8'h00;
  localparam logic [DATA_W-1:0] CNT_MAX     = 8'hFF;
  localparam logic [DATA_W-1:0] CNT_ONE     = 8'h01;
  localparam logic [DATA_W-1:0] ZERO8       = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_A_RST  = 8'h00;
  localparam logic              PWR_OFF_RST = 1'b0;

  // Prescaler tap masks
  localparam logic [PRESC_W-1:0] PRE_MASK_8    = 10'h007;
  localparam logic [PRESC_W-1:0] PRE_MASK_64   = 10'h03F;
  localparam logic [PRESC_W-1:0] PRE_MASK_256  = 10'h0FF;
  localparam logic [PRESC_W-1:0] PRE_MASK_1024 = 10'h3FF;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_CTC    = 2'b01,
    MODE_FAST   = 2'b10,
    MODE_PHASE  = 2'b11
  } wave_mode_e;

  typedef enum logic [2:0] {
    CS_STOP     = 3'b000,
    CS_DIV1     = 3'b001,
    CS_DIV8     = 3'b010,
    CS_DIV64    = 3'b011,
    CS_DIV256   = 3'b100,
    CS_DIV1024  = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } clk_sel_e;

  typedef enum logic [1:0] {
    COM_OFF    = 2'b00,
    COM_TOGGLE = 2'b01,
    COM_CLEAR  = 2'b10,
    COM_SET    = 2'b11
  } out_mode_e;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } dir_e;

endpackage

// *** timer8_tick_select.sv ***
// Clock source and edge selection producing the one-cycle timer tick
`timescale 1ns/10ps
module timer8_tick_select
  import timer8_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  input  wire logic     enable_i,
  input  wire clk_sel_e sel_i,
  input  wire logic     ext_i,
  output logic          tick_o
);

  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic               ext_prev;
    logic               tick;
  } tick_state_s;

  tick_state_s q;
  tick_state_s d;

  function automatic logic div_hit(input logic [PRESC_W-1:0] presc, input logic [PRESC_W-1:0] mask);
    div_hit = ((presc & mask) == mask);
  endfunction

  always_comb begin
    d          = q;
    d.ext_prev = ext_i;
    d.presc    = enable_i ? PRESC_W'(q.presc + 1'b1) : '0;
    d.tick     = 1'b0;
    unique case (sel_i)
      CS_STOP:     d.tick = 1'b0;
      CS_DIV1:     d.tick = enable_i;
      CS_DIV8:     d.tick = enable_i & div_hit(q.presc, PRE_MASK_8);
      CS_DIV64:    d.tick = enable_i & div_hit(q.presc, PRE_MASK_64);
      CS_DIV256:   d.tick = enable_i & div_hit(q.presc, PRE_MASK_256);
      CS_DIV1024:  d.tick = enable_i & div_hit(q.presc, PRE_MASK_1024);
      CS_EXT_FALL: d.tick = enable_i & q.ext_prev & ~ext_i;
      CS_EXT_RISE: d.tick = enable_i & ~q.ext_prev & ext_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;

  AST_DIV1_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
    (enable_i && sel_i == CS_DIV1) |=> tick_o)
    else $error("Undivided source gave no tick");

  AST_EXT_RISE_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
    (enable_i && sel_i == CS_EXT_RISE && !q.ext_prev && ext_i) |=> tick_o)
    else $error("Rising pin edge gave no tick");

endmodule // timer8_tick_select

// *** timer8_compare_unit.sv ***
// One compare unit: double-buffered compare value and match detection
`timescale 1ns/10ps
module timer8_compare_unit
  import timer8_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              buffered_i,
  input  wire logic              update_i,
  input  wire logic [DATA_W-1:0] count_i,
  input  wire logic              tick_i,
  input  wire logic              block_i,
  output logic [DATA_W-1:0]      cmp_o,
  output logic [DATA_W-1:0]      buf_o,
  output logic                   match_o,
  output logic                   flag_set_o
);

  typedef struct packed {
    logic [DATA_W-1:0] buffer;
    logic [DATA_W-1:0] active;
  } cmp_state_s;

  cmp_state_s q;
  cmp_state_s d;

  always_comb begin
    d = q;
    if (buffered_i && update_i) begin
      d.active = q.buffer;
    end
    if (wr_i) begin
      d.buffer = wdata_i;
      if (!buffered_i) begin
        d.active = wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cmp_o      = q.active;
  assign buf_o      = q.buffer;
  assign match_o    = (count_i == q.active);
  assign flag_set_o = tick_i & match_o & ~block_i;

  AST_CMP_DIRECT: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && !buffered_i) |=> (cmp_o == $past(wdata_i)))
    else $error("Unbuffered compare write not applied");

endmodule // timer8_compare_unit

// *** timer8_counter_core.sv ***
// Top of the 8-bit timer/counter: registers, counter, flags and waveforms
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/10ps

// Functional notes
// - Bottom indication is high whenever the count equals 0x00.
// - Maximum indication is high whenever the count equals 0xFF.
// - Top is 0xFF or compare A, chosen by the operating mode and, in the PWM modes, by the top select bit of control register A.
// - Count and both compare registers are 8 bits wide.
// - Every timer request shows as a bit in the flag register.
// - Each request has its own mask bit; only unmasked ones reach the processor.
// - Counter ticks from the internal prescaler or the external count pin.
// - Clock select picks source and edge; its output is the timer tick.
// - A three-bit source field in control register B picks the source.
// - Both compare values are compared with the count at all times.
// - Waveform generator drives PWM or frequency output on pins A and B.
// - A match on unit A or B sets that unit's compare flag.
// - The counter can count up or down.
// - A count step changes the value by exactly one.
// - A direction signal chooses increment or decrement.
// - The clear signal forces every count bit to zero.
// - Source field zero stops the counter.
// - A processor count write beats clear or count in the same cycle.
// - The count register is readable and writable with or without ticks.
// - A match sets its flag on the following tick, not at once.
module timer8_counter_core
  import timer8_pkg::*;
(
  input  wire logic              SYS_CLK_I,
  input  wire logic              RST_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [DATA_W-1:0] WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic [DATA_W-1:0]      RDATA_O,
  input  wire logic              EXT_COUNT_INPUT_I,
  output logic                   WAVE_OUT_A_O,
  output logic                   WAVE_OUT_B_O,
  output logic [FLAG_W-1:0]      IRQ_O,
  output logic                   BOTTOM_O,
  output logic                   MAX_O
);

  typedef struct packed {
    logic [DATA_W-1:0] ctrl_a;
    clk_sel_e          cs;
    logic [DATA_W-1:0] cnt;
    dir_e              dir;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] mask;
    logic              pwr_off;
    logic              block;
    logic              wave_a;
    logic              wave_b;
    logic [DATA_W-1:0] rdata;
    logic [FLAG_W-1:0] irq;
    logic              bottom;
    logic              max;
  } core_state_s;

  core_state_s q;
  core_state_s d;

  logic              timer_tick;
  logic [DATA_W-1:0] cmp_a;
  logic [DATA_W-1:0] cmp_b;
  logic [DATA_W-1:0] buf_a;
  logic [DATA_W-1:0] buf_b;
  logic              match_a;
  logic              match_b;
  logic              set_a;
  logic              set_b;
  logic              wr_cnt;
  logic              wr_ca;
  logic              wr_cb;
  logic              pwm;
  logic              at_top;
  logic              cnt_clear;
  logic              ovf_set;
  logic              buf_update;
  logic [DATA_W-1:0] top_val;
  wave_mode_e        mode;
  out_mode_e         com_a;
  out_mode_e         com_b;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic is_pwm(input wave_mode_e m);
    is_pwm = (m == MODE_FAST) || (m == MODE_PHASE);
  endfunction

  function automatic logic [DATA_W-1:0] step_cnt(input logic [DATA_W-1:0] cnt, input dir_e dir);
    if (dir == DIR_DOWN) begin
      step_cnt = DATA_W'(cnt - CNT_ONE);
    end else begin
      step_cnt = DATA_W'(cnt + CNT_ONE);
    end
  endfunction

  function automatic logic wave_next(input logic cur, input out_mode_e com, input wave_mode_e m,
                                     input logic match, input logic wrap, input dir_e dir);
    logic nxt;
    nxt = cur;
    unique case (m)
      MODE_NORMAL, MODE_CTC: begin
        if (match) begin
          unique case (com)
            COM_OFF:    nxt = cur;
            COM_TOGGLE: nxt = ~cur;
            COM_CLEAR:  nxt = 1'b0;
            COM_SET:    nxt = 1'b1;
          endcase
        end
      end
      MODE_FAST: begin
        if (com == COM_CLEAR || com == COM_SET) begin
          if (match) begin
            nxt = (com == COM_SET);
          end else if (wrap) begin
            nxt = (com == COM_CLEAR);
          end
        end
      end
      MODE_PHASE: begin
        if ((com == COM_CLEAR || com == COM_SET) && match) begin
          nxt = (dir == DIR_UP) ? (com == COM_SET) : (com == COM_CLEAR);
        end
      end
    endcase
    if (com == COM_OFF) begin
      nxt = 1'b0;
    end
    wave_next = nxt;
  endfunction

  timer8_tick_select u_tick (
    .clk_i    (SYS_CLK_I),
    .rst_i    (RST_I),
    .enable_i (~q.pwr_off),
    .sel_i    (q.cs),
    .ext_i    (EXT_COUNT_INPUT_I),
    .tick_o   (timer_tick)
  );

  timer8_compare_unit u_cmp_a (
    .clk_i      (SYS_CLK_I),
    .rst_i      (RST_I),
    .wr_i       (wr_ca),
    .wdata_i    (WDATA_I),
    .buffered_i (pwm),
    .update_i   (buf_update),
    .count_i    (q.cnt),
    .tick_i     (timer_tick),
    .block_i    (q.block),
    .cmp_o      (cmp_a),
    .buf_o      (buf_a),
    .match_o    (match_a),
    .flag_set_o (set_a)
  );

  timer8_compare_unit u_cmp_b (
    .clk_i      (SYS_CLK_I),
    .rst_i      (RST_I),
    .wr_i       (wr_cb),
    .wdata_i    (WDATA_I),
    .buffered_i (pwm),
    .update_i   (buf_update),
    .count_i    (q.cnt),
    .tick_i     (timer_tick),
    .block_i    (q.block),
    .cmp_o      (cmp_b),
    .buf_o      (buf_b),
    .match_o    (match_b),
    .flag_set_o (set_b)
  );

  // Decode and mode
  always_comb begin
    wr_cnt     = WR_I & hit(ADDR_I, OFS_COUNT);
    wr_ca      = WR_I & hit(ADDR_I, OFS_CMP_A);
    wr_cb      = WR_I & hit(ADDR_I, OFS_CMP_B);
    mode       = wave_mode_e'(q.ctrl_a[CA_MODE_LSB +: 2]);
    com_a      = out_mode_e'(q.ctrl_a[CA_COMA_LSB +: 2]);
    com_b      = out_mode_e'(q.ctrl_a[CA_COMB_LSB +: 2]);
    pwm        = is_pwm(mode);
    top_val    = ((mode == MODE_CTC) || (pwm && q.ctrl_a[CA_TOPSEL_BIT])) ? cmp_a : CNT_MAX;
    at_top     = (q.cnt == top_val);
    cnt_clear  = timer_tick & at_top & ((mode == MODE_CTC) || (mode == MODE_FAST));
    buf_update = timer_tick & at_top;
    unique case (mode)
      MODE_NORMAL, MODE_CTC: ovf_set = timer_tick & (q.cnt == CNT_MAX);
      MODE_FAST:             ovf_set = timer_tick & at_top;
      MODE_PHASE:            ovf_set = timer_tick & (q.cnt == CNT_BOTTOM) & (q.dir == DIR_DOWN);
    endcase
  end

  // Next state
  always_comb begin
    d = q;

    // Register writes
    if (WR_I && hit(ADDR_I, OFS_CTRL_A)) begin
      d.ctrl_a = WDATA_I;
    end
    if (WR_I && hit(ADDR_I, OFS_CTRL_B)) begin
      d.cs = clk_sel_e'(WDATA_I[CB_CS_LSB +: 3]);
    end
    if (WR_I && hit(ADDR_I, OFS_MASK)) begin
      d.mask = WDATA_I[FLAG_W-1:0];
    end
    if (WR_I && hit(ADDR_I, OFS_POWER)) begin
      d.pwr_off = WDATA_I[PWR_OFF_BIT];
    end

    // Counter, advanced only on the tick
    if (wr_cnt) begin
      d.cnt   = WDATA_I;
      d.block = 1'b1;
    end else if (timer_tick) begin
      d.block = 1'b0;
      if (cnt_clear) begin
        d.cnt = ZERO8;
      end else if (mode == MODE_PHASE) begin
        if (q.dir == DIR_UP && at_top) begin
          d.dir = DIR_DOWN;
          d.cnt = step_cnt(q.cnt, DIR_DOWN);
        end else if (q.dir == DIR_DOWN && q.cnt == CNT_BOTTOM) begin
          d.dir = DIR_UP;
          d.cnt = step_cnt(q.cnt, DIR_UP);
        end else begin
          d.cnt = step_cnt(q.cnt, q.dir);
        end
      end else begin
        d.dir = DIR_UP;
        d.cnt = step_cnt(q.cnt, DIR_UP);
      end
    end

    // Sticky flags, set wins over a write-one clear
    if (WR_I && hit(ADDR_I, OFS_FLAG)) begin
      d.flags = q.flags & ~WDATA_I[FLAG_W-1:0];
    end
    d.flags[FLG_OVF]  = d.flags[FLG_OVF] | ovf_set;
    d.flags[FLG_CMPA] = d.flags[FLG_CMPA] | set_a;
    d.flags[FLG_CMPB] = d.flags[FLG_CMPB] | set_b;
    d.irq             = d.flags & d.mask;

    // Waveform outputs
    d.wave_a = wave_next(q.wave_a, com_a, mode, set_a, timer_tick & at_top, q.dir);
    d.wave_b = wave_next(q.wave_b, com_b, mode, set_b, timer_tick & at_top, q.dir);

    // Indications
    d.bottom = (d.cnt == CNT_BOTTOM);
    d.max    = (d.cnt == CNT_MAX);

    // Read data, valid one cycle after the strobe
    d.rdata = ZERO8;
    if (RD_I) begin
      unique case (ADDR_I)
        OFS_CTRL_A: d.rdata = q.ctrl_a;
        OFS_CTRL_B: d.rdata = DATA_W'(q.cs);
        OFS_COUNT:  d.rdata = q.cnt;
        OFS_CMP_A:  d.rdata = buf_a;
        OFS_CMP_B:  d.rdata = buf_b;
        OFS_FLAG:   d.rdata = DATA_W'(q.flags);
        OFS_MASK:   d.rdata = DATA_W'(q.mask);
        OFS_POWER:  d.rdata = DATA_W'(q.pwr_off);
        OFS_STATUS: d.rdata = DATA_W'({q.dir, at_top, q.max, q.bottom});
        default:    d.rdata = ZERO8;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      q         <= '0;
      q.ctrl_a  <= CTRL_A_RST;
      q.pwr_off <= PWR_OFF_RST;
      q.bottom  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign RDATA_O      = q.rdata;
  assign WAVE_OUT_A_O = q.wave_a;
  assign WAVE_OUT_B_O = q.wave_b;
  assign IRQ_O        = q.irq;
  assign BOTTOM_O     = q.bottom;
  assign MAX_O        = q.max;

  AST_BOTTOM_IND: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    BOTTOM_O == (q.cnt == CNT_BOTTOM))
    else $error("Bottom indication disagrees with count");

  AST_MAX_IND: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    MAX_O == (q.cnt == CNT_MAX))
    else $error("Maximum indication disagrees with count");

  AST_CTC_TOP_CLEAR: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (timer_tick && !wr_cnt && mode == MODE_CTC && q.cnt == cmp_a) |=> (q.cnt == CNT_BOTTOM))
    else $error("Count did not clear at compare A top");

  AST_STOPPED: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    ((q.cs == CS_STOP && !wr_cnt)[*3]) |=> $stable(q.cnt))
    else $error("Counter moved with no source selected");

  AST_WRITE_WINS: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    wr_cnt |=> (q.cnt == $past(WDATA_I)) && q.block)
    else $error("Count write lost to count or clear");

  AST_STEP_UP: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (timer_tick && !wr_cnt && mode == MODE_NORMAL) |=> (q.cnt == DATA_W'($past(q.cnt) + CNT_ONE)))
    else $error("Up step not exactly one");

  AST_PHASE_DOWN: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (timer_tick && !wr_cnt && mode == MODE_PHASE && q.dir == DIR_DOWN && q.cnt != CNT_BOTTOM)
    |=> (q.cnt == DATA_W'($past(q.cnt) - CNT_ONE)))
    else $error("Down step not exactly one");

  AST_FLAG_A_SET: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (timer_tick && match_a && !q.block) |=> q.flags[FLG_CMPA])
    else $error("Compare A match did not set its flag");

  AST_NO_FLAG_WITHOUT_TICK: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (!q.flags[FLG_CMPB] && !timer_tick) |=> !q.flags[FLG_CMPB])
    else $error("Compare B flag set without a tick");

  AST_IRQ_MASK: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    IRQ_O == (q.flags & q.mask))
    else $error("Request output not flag and mask");

  AST_POWER_OFF: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    ($past(q.pwr_off) && q.pwr_off) |-> !timer_tick)
    else $error("Tick while powered off");

  AST_MATCH_B: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    match_b == (q.cnt == cmp_b))
    else $error("Compare B match disagrees with count");

endmodule // timer8_counter_core

// *** timer8_counter_core_tb.sv ***
// Self-checking testbench of the 8-bit timer/counter core
`timescale 1ns/10ps
module timer8_counter_core_tb;
  import timer8_pkg::*;

  logic              sys_clk;
  logic              rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              ext_pin;
  logic              wave_a;
  logic              wave_b;
  logic [FLAG_W-1:0] irq;
  logic              bottom;
  logic              max_ind;
  int                error_cnt;
  int                compares;
  int                toggles;
  logic [DATA_W-1:0] v1;
  logic [DATA_W-1:0] v2;
  logic              prev_a;

  timer8_counter_core DUT (
    .SYS_CLK_I         (sys_clk),
    .RST_I             (rst),
    .ADDR_I            (addr),
    .WDATA_I           (wdata),
    .WR_I              (wr),
    .RD_I              (rd),
    .RDATA_O           (rdata),
    .EXT_COUNT_INPUT_I (ext_pin),
    .WAVE_OUT_A_O      (wave_a),
    .WAVE_OUT_B_O      (wave_b),
    .IRQ_O             (irq),
    .BOTTOM_O          (bottom),
    .MAX_O             (max_ind)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("Checks: %0d, mismatches: %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd   <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask

  task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    reg_rd(a, d);
    chk(name, exp, d);
  endtask

  task automatic pin_pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      ext_pin <= 1'b1;
      cycles(4);
      ext_pin <= 1'b0;
      cycles(4);
    end
  endtask

  initial begin
    #40000;
    error_cnt++;
    $display("MISMATCH watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    error_cnt = 0;
    compares  = 0;
    rst       = 1'b1;
    addr      = 4'h0;
    wdata     = 8'h00;
    wr        = 1'b0;
    rd        = 1'b0;
    ext_pin   = 1'b0;
    cycles(6);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk("bottom_rst", 8'h01, {7'h00, bottom});
    chk("irq_rst", 8'h00, {5'h00, irq});
    rd_chk("ctrl_a_rst", OFS_CTRL_A, CTRL_A_RST);
    rd_chk("ctrl_b_rst", OFS_CTRL_B, 8'h00);
    rd_chk("power_rst", OFS_POWER, 8'h00);
    rd_chk("unmapped", 4'hF, 8'h00);
    reg_wr(4'hF, 8'hA5);
    rd_chk("unmapped_wr", 4'hF, 8'h00);
    reg_wr(OFS_POWER, 8'h00);
    // Stopped counter keeps written value
    reg_wr(OFS_COUNT, 8'h55);
    cycles(10);
    rd_chk("count_stopped", OFS_COUNT, 8'h55);
    // Extreme indications
    reg_wr(OFS_COUNT, 8'hFF);
    cycles(2);
    chk("max_ff", 8'h02, {6'h00, max_ind, bottom});
    rd_chk("status_ff", OFS_STATUS, 8'h06);
    reg_wr(OFS_COUNT, 8'h00);
    cycles(2);
    chk("bottom_00", 8'h01, {6'h00, max_ind, bottom});
    // Normal mode overflow, flag and mask
    reg_wr(OFS_FLAG, 8'h07);
    reg_wr(OFS_MASK, 8'h01);
    reg_wr(OFS_COUNT, 8'hFE);
    reg_wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    cycles(10);
    reg_wr(OFS_CTRL_B, {5'h00, CS_STOP});
    cycles(2);
    chk("irq_ovf", 8'h01, {7'h00, irq[FLG_OVF]});
    reg_rd(OFS_FLAG, v1);
    chk("flag_ovf", 8'h01, v1 & 8'h01);
    reg_wr(OFS_MASK, 8'h00);
    cycles(2);
    chk("irq_masked", 8'h00, {5'h00, irq});
    reg_rd(OFS_FLAG, v1);
    chk("flag_kept", 8'h01, v1 & 8'h01);
    reg_wr(OFS_FLAG, 8'h01);
    reg_rd(OFS_FLAG, v1);
    chk("flag_cleared", 8'h00, v1 & 8'h01);
    // Single steps upward, two cycles between reads
    reg_wr(OFS_COUNT, 8'h30);
    reg_wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    cycles(4);
    reg_rd(OFS_COUNT, v1);
    reg_rd(OFS_COUNT, v2);
    chk("step_up", v1 + 8'h02, v2);
    // Write while running wins over counting
    reg_wr(OFS_COUNT, 8'h80);
    reg_rd(OFS_COUNT, v1);
    compares++;
    if (v1 < 8'h80 || v1 > 8'h84) begin
      error_cnt++;
      $display("MISMATCH count_after_write expected 80..84 seen %h", v1);
    end
    // Phase correct mode turns at top and counts down
    reg_wr(OFS_CTRL_B, {5'h00, CS_STOP});
    reg_wr(OFS_CTRL_A, 8'h03);
    reg_wr(OFS_COUNT, 8'hF0);
    reg_wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    cycles(40);
    reg_rd(OFS_COUNT, v1);
    reg_rd(OFS_COUNT, v2);
    chk("step_down", v1 - 8'h02, v2);
    reg_rd(OFS_STATUS, v1);
    chk("dir_down", 8'h08, v1 & 8'h08);
    // CTC mode: top from compare A, both compare flags, toggle on A
    reg_wr(OFS_CTRL_B, {5'h00, CS_STOP});
    reg_wr(OFS_CTRL_A, 8'h41);
    reg_wr(OFS_CMP_A, 8'h10);
    reg_wr(OFS_CMP_B, 8'h08);
    reg_wr(OFS_COUNT, 8'h00);
    reg_wr(OFS_FLAG, 8'h07);
    reg_wr(OFS_MASK, 8'h06);
    rd_chk("cmp_a_rd", OFS_CMP_A, 8'h10);
    reg_wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    toggles = 0;
    @(negedge sys_clk);
    prev_a = wave_a;
    repeat (60) begin
      @(negedge sys_clk);
      if (wave_a !== prev_a) toggles++;
      prev_a = wave_a;
    end
    compares++;
    if (toggles < 3) begin
      error_cnt++;
      $display("MISMATCH wave_a_toggles expected 3 or more seen %0d", toggles);
    end
    chk("wave_b_off", 8'h00, {7'h00, wave_b});
    repeat (6) begin
      reg_rd(OFS_COUNT, v1);
      compares++;
      if (v1 > 8'h10) begin
        error_cnt++;
        $display("MISMATCH ctc_top expected 10 or less seen %h", v1);
      end
    end
    reg_rd(OFS_FLAG, v1);
    chk("cmp_flags", 8'h06, v1 & 8'h06);
    chk("irq_cmp", 8'h06, {5'h00, irq});
    // External pin, rising then falling edges
    reg_wr(OFS_CTRL_B, {5'h00, CS_STOP});
    reg_wr(OFS_CTRL_A, 8'h00);
    reg_wr(OFS_COUNT, 8'h00);
    reg_wr(OFS_CTRL_B, {5'h00, CS_EXT_RISE});
    pin_pulses(4);
    rd_chk("ext_rise", OFS_COUNT, 8'h04);
    reg_wr(OFS_CTRL_B, {5'h00, CS_EXT_FALL});
    pin_pulses(3);
    rd_chk("ext_fall", OFS_COUNT, 8'h07);
    // Prescaler by eight
    reg_wr(OFS_CTRL_B, {5'h00, CS_STOP});
    reg_wr(OFS_COUNT, 8'h00);
    reg_wr(OFS_CTRL_B, {5'h00, CS_DIV8});
    cycles(78);
    reg_wr(OFS_CTRL_B, {5'h00, CS_STOP});
    reg_rd(OFS_COUNT, v1);
    compares++;
    if (v1 < 8'h09 || v1 > 8'h0B) begin
      error_cnt++;
      $display("MISMATCH presc8_count expected 09..0B seen %h", v1);
    end
    // Power-off bit holds the timer idle
    reg_wr(OFS_COUNT, 8'h20);
    reg_wr(OFS_POWER, 8'h01);
    reg_wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    cycles(20);
    rd_chk("power_off", OFS_COUNT, 8'h20);
    reg_wr(OFS_POWER, 8'h00);
    cycles(5);
    reg_rd(OFS_COUNT, v1);
    reg_rd(OFS_COUNT, v2);
    chk("power_on", v1 + 8'h02, v2);
    reg_wr(OFS_CTRL_B, {5'h00, CS_STOP});
    // Prescaler by sixty-four
    reg_wr(OFS_COUNT, 8'h00);
    reg_wr(OFS_CTRL_B, {5'h00, CS_DIV64});
    cycles(200);
    reg_wr(OFS_CTRL_B, {5'h00, CS_STOP});
    reg_rd(OFS_COUNT, v1);
    compares++;
    if (v1 < 8'h03 || v1 > 8'h04) begin
      error_cnt++;
      $display("MISMATCH presc64_count expected 03..04 seen %h", v1);
    end
    // Fast PWM: buffered compares, A clears on match, B sets on match
    reg_wr(OFS_CTRL_A, 8'hB2);
    reg_wr(OFS_CMP_A, 8'h40);
    reg_wr(OFS_CMP_B, 8'hC0);
    reg_wr(OFS_COUNT, 8'hFE);
    reg_wr(OFS_FLAG, 8'h07);
    reg_wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    cycles(10);
    reg_wr(OFS_CTRL_B, {5'h00, CS_STOP});
    cycles(2);
    chk("fast_wrap", 8'h01, {6'h00, wave_b, wave_a});
    rd_chk("cmp_a_buf", OFS_CMP_A, 8'h40);
    reg_wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    cycles(80);
    reg_wr(OFS_CTRL_B, {5'h00, CS_STOP});
    cycles(2);
    chk("fast_match_a", 8'h00, {6'h00, wave_b, wave_a});
    reg_wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    cycles(120);
    reg_wr(OFS_CTRL_B, {5'h00, CS_STOP});
    cycles(2);
    chk("fast_match_b", 8'h02, {6'h00, wave_b, wave_a});
    rd_chk("fast_flags", OFS_FLAG, 8'h07);
    finish_test();
  end
endmodule // timer8_counter_core_tb
